/* File: design/pesd_regs.svh */
/*
 * Register offsets, field positions, reset values and event encodings
 * for the performance event select decoder.
 * Assumes inclusion by its bare name from the top module.
 */
`ifndef PESD_REGS_SVH
`define PESD_REGS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define PESD_SEL_OFS 4'h0
`define PESD_CNT_OFS 4'h4
`define PESD_STAT_OFS 4'h8

// ----------------------------------------------------------------------------
// Select register fields, reset values and counter index
// ----------------------------------------------------------------------------
`define PESD_SEL_EVT_LSB 0
`define PESD_SEL_MASK_LSB 8
`define PESD_SEL_EDGE_BIT 16
`define PESD_SEL_ANY_BIT 17
`define PESD_SEL_EN_BIT 18
`define PESD_SEL_THR_LSB 24
`define PESD_SEL_RESET 32'h00000000
`define PESD_CNT_RESET 32'h00000000
`define PESD_COUNTER_INDEX 2'h0

// ----------------------------------------------------------------------------
// Event numbers
// ----------------------------------------------------------------------------
`define PESD_EV_UOP_QUEUE 8'h79
`define PESD_EV_ICACHE 8'h80
`define PESD_EV_INSTR_TRANSLATION_BUFFER_MISS 8'h85
`define PESD_EV_DECODE_STALL 8'h87
`define PESD_EV_BR_EXEC 8'h88
`define PESD_EV_BR_MISP 8'h89
`define PESD_EV_UNDELIVERED 8'h9C
`define PESD_EV_PORT_DISP 8'hA1
`define PESD_EV_RES_STALL 8'hA2
`define PESD_EV_PEND_LOAD 8'hA3
`define PESD_EV_LOOP_DET 8'hA8
`define PESD_EV_PATH_SWITCH 8'hAB
`define PESD_EV_OPC_FILL 8'hAC
`define PESD_EV_INSTR_TRANSLATION_BUFFER_FLUSH 8'hAE
`define PESD_EV_OFFCORE 8'hB0

// ----------------------------------------------------------------------------
// Unit mask values
// ----------------------------------------------------------------------------
`define PESD_UM_ANY_PATH 8'h3C
`define PESD_UM_ALL 8'hFF
`define PESD_UM_TAKEN 8'h80
`define PESD_UM_NOT_TAKEN 8'h40
`define PESD_UM_COND 8'h01
`define PESD_UM_TYPES 8'h3F
`define PESD_UM_PORT2 8'h0C
`define PESD_UM_PORT3 8'h30

`endif

/* File: design/pesd_pkg.sv */
/*
 * Types shared by the performance event select decoder.
 * Assumes the constants header sits in the include path.
 */
package pesd_pkg;

    // Per-cycle condition strobes from the core pipeline units
    typedef struct packed {
        logic [2:0] uq_any_path;     // Uops into decoded_uop_queue this cycle
        logic fetch_stall;
        logic icache_miss;
        logic instr_translation_buffer_walk_start;
        logic instr_translation_buffer_walk_done;
        logic walker_busy;
        logic second_level_translation_buffer_hit;
        logic lcp_stall;
        logic iq_full;
        logic [5:0] br_type;         // Cond, direct, indirect, return, call, ind call
        logic br_valid;
        logic br_taken;
        logic br_misp;
        logic [2:0] undelivered;     // Slots not given to rename_stage
        logic [5:0] port_disp;       // Dispatch on ports 0 to 5
        logic stall_any;
        logic stall_rs;
        logic stall_sb;
        logic stall_rob;
        logic [3:0] pend_thread;     // L2 miss, memory, no execute, L1 miss
        logic [3:0] pend_other;      // Same from the sibling thread
        logic [2:0] lsd_uops;
        logic path_switch;
        logic switch_penalty;
        logic opc_fill_big;
        logic instr_translation_buffer_flush;
        logic req_data_rd;
        logic req_code_rd;
        logic req_rfo;
    } pesd_cond_t;

    // Packed view of the select register
    typedef struct packed {
        logic [7:0] threshold;
        logic [4:0] reserved;        // Bits 23:19 read back as zero
        logic enable;
        logic any_thread;
        logic edge_det;
        logic [7:0] umask;
        logic [7:0] event_num;
    } pesd_sel_t;

    // Bus slave states
    typedef enum logic [1:0] {
        PESD_IDLE = 2'b01,
        PESD_ACK = 2'b10
    } pesd_bus_t;

endpackage

/* File: design/pesd_top.sv */
/*
 * Performance event select decoder with one general counter.
 * Software picks an event number and unit mask over Avalon-MM; the
 * selected pipeline condition is added to the counter each clock.
 * Assumes condition strobes arrive synchronous to clk_in.
 */
// Design decisions made here: the register addresses and the Avalon-MM register port.
//
// Behaviour
// - Event 79H mask 3CH adds uops delivered to queue from every path.
// - Event 80H mask 04H counts cycles of fetch stall from cache or TLB miss.
// - Event 80H mask 02H counts instruction cache misses, uncacheable included.
// - Event 85H counts walk starts, walk completions, walker busy, second-level hits.
// - Event 87H counts prefix length stalls and instruction queue full cycles.
// - Branch type bits count only with a direction bit; taken needs a type.
// - Not-taken qualifier applies only with the conditional type bit.
// - Event 88H mask FFH counts every executed near branch, squashed ones too.
// - Event 89H uses the same encoding for mispredicted branches.
// - Event 9CH mask 01H counts undelivered slots; threshold may qualify them.
// - Event A1H counts dispatch cycles per port with the listed masks.
// - Event A2H counts allocation stalls: any, station, store buffer, reorder buffer.
// - Pending load event counts L2 miss, memory, L1 miss, no-execute cycles; L1 miss counts only with COUNTER_INDEX 2.
// - All-threads qualifier makes pending load counts per core.
// - Event A8H mask 01H counts uops from the loop stream detector.
// - Event ABH counts path switches (01H) and their delay cycles (02H).
// - Event ACH mask 08H counts fills needing more than three lines.
// - Event AEH mask 01H counts instruction TLB flushes.
// - Offcore event counts demand data, code and ownership reads.
// - Threshold one adds one per cycle with a nonzero condition.
// - Edge with threshold counts only transitions into the condition.
`timescale 1ns/1ps
`default_nettype none
`include "pesd_regs.svh"

module pesd_top
    import pesd_pkg::*;
#(
    parameter int CNT_W = 32,
    parameter logic [1:0] COUNTER_INDEX = `PESD_COUNTER_INDEX
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Pipeline condition strobes
    input wire pesd_cond_t cond_in,
    // Avalon-MM slave
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic avs_response_out,
    // Counter value
    output logic [CNT_W-1:0] count_out
);

    // ------------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------------

    // Branch qualifier match shared by executed and mispredicted events
    function automatic logic br_match(input logic [7:0] um, input logic [5:0] typ,
                                      input logic taken);
        logic type_hit;
        logic dir_hit;
        type_hit = |(um[5:0] & typ);
        // Not-taken only honoured for the conditional type
        dir_hit = (um[7] & taken) | (um[6] & ~taken & typ[0] & um[0]);
        br_match = type_hit & dir_hit;
    endfunction

    // Byte-lane merge of a write into a register word
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] be);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        lane_merge = res;
    endfunction

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    pesd_sel_t sel_q, sel_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic above_q, above_d;
    pesd_bus_t bus_q, bus_d;
    logic [31:0] rdata_q, rdata_d;
    logic wait_q, wait_d;
    logic resp_q, resp_d;
    logic [3:0] amount;
    logic [3:0] pend;
    logic hit;

    // Selected condition as a per-cycle amount
    always_comb begin
        amount = 4'h0;
        pend = cond_in.pend_thread;
        if (sel_q.any_thread) begin
            pend = cond_in.pend_thread | cond_in.pend_other;
        end
        unique case (sel_q.event_num)
            `PESD_EV_UOP_QUEUE: begin
                if (sel_q.umask == `PESD_UM_ANY_PATH) begin
                    amount = {1'b0, cond_in.uq_any_path};
                end
            end
            `PESD_EV_ICACHE: begin
                amount = {3'h0, (sel_q.umask[2] & cond_in.fetch_stall)
                               | (sel_q.umask[1] & cond_in.icache_miss)};
            end
            `PESD_EV_INSTR_TRANSLATION_BUFFER_MISS: begin
                amount = {3'h0, (sel_q.umask[0] & cond_in.instr_translation_buffer_walk_start)
                               | (sel_q.umask[1] & cond_in.instr_translation_buffer_walk_done)
                               | (sel_q.umask[2] & cond_in.walker_busy)
                               | (sel_q.umask[4] & cond_in.second_level_translation_buffer_hit)};
            end
            `PESD_EV_DECODE_STALL: begin
                amount = {3'h0, (sel_q.umask[0] & cond_in.lcp_stall)
                               | (sel_q.umask[2] & cond_in.iq_full)};
            end
            `PESD_EV_BR_EXEC: begin
                if (sel_q.umask == `PESD_UM_ALL) begin
                    amount = {3'h0, cond_in.br_valid};
                end else begin
                    amount = {3'h0, cond_in.br_valid
                             & br_match(sel_q.umask, cond_in.br_type, cond_in.br_taken)};
                end
            end
            `PESD_EV_BR_MISP: begin
                if (sel_q.umask == `PESD_UM_ALL) begin
                    amount = {3'h0, cond_in.br_valid & cond_in.br_misp};
                end else begin
                    amount = {3'h0, cond_in.br_valid & cond_in.br_misp
                             & br_match(sel_q.umask, cond_in.br_type, cond_in.br_taken)};
                end
            end
            `PESD_EV_UNDELIVERED: begin
                if (sel_q.umask == `PESD_UM_COND) begin
                    amount = {1'b0, cond_in.undelivered};
                end
            end
            `PESD_EV_PORT_DISP: begin
                amount = {3'h0, (sel_q.umask[0] & cond_in.port_disp[0])
                               | (sel_q.umask[1] & cond_in.port_disp[1])
                               | (|(sel_q.umask & `PESD_UM_PORT2) & cond_in.port_disp[2])
                               | (|(sel_q.umask & `PESD_UM_PORT3) & cond_in.port_disp[3])
                               | (sel_q.umask[6] & cond_in.port_disp[4])
                               | (sel_q.umask[7] & cond_in.port_disp[5])};
            end
            `PESD_EV_RES_STALL: begin
                amount = {3'h0, (sel_q.umask[0] & cond_in.stall_any)
                               | (sel_q.umask[2] & cond_in.stall_rs)
                               | (sel_q.umask[3] & cond_in.stall_sb)
                               | (sel_q.umask[4] & cond_in.stall_rob)};
            end
            `PESD_EV_PEND_LOAD: begin
                // Memory loads on counters 0 to 3, L1 miss on counter two only
                amount = {3'h0, (sel_q.umask[0] & pend[0])
                               | (sel_q.umask[1] & pend[1])
                               | (sel_q.umask[2] & pend[2])
                               | (sel_q.umask[3] & pend[3] & (COUNTER_INDEX == 2'h2))};
            end
            `PESD_EV_LOOP_DET: begin
                if (sel_q.umask == `PESD_UM_COND) begin
                    amount = {1'b0, cond_in.lsd_uops};
                end
            end
            `PESD_EV_PATH_SWITCH: begin
                amount = {3'h0, (sel_q.umask[0] & cond_in.path_switch)
                               | (sel_q.umask[1] & cond_in.switch_penalty)};
            end
            `PESD_EV_OPC_FILL: begin
                amount = {3'h0, sel_q.umask[3] & cond_in.opc_fill_big};
            end
            `PESD_EV_INSTR_TRANSLATION_BUFFER_FLUSH: begin
                amount = {3'h0, sel_q.umask[0] & cond_in.instr_translation_buffer_flush};
            end
            `PESD_EV_OFFCORE: begin
                amount = {3'h0, (sel_q.umask[0] & cond_in.req_data_rd)
                               | (sel_q.umask[1] & cond_in.req_code_rd)
                               | (sel_q.umask[2] & cond_in.req_rfo)};
            end
            default: begin
                amount = 4'h0;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Counter with threshold and edge qualification
    // ------------------------------------------------------------------------
    always_comb begin
        hit = ({4'h0, amount} >= sel_q.threshold);
        above_d = hit;
        cnt_d = cnt_q;
        if (sel_q.enable) begin
            if (sel_q.threshold == 8'h00) begin
                cnt_d = cnt_q + CNT_W'(amount);
            end else if (sel_q.edge_det) begin
                if (hit && !above_q) begin
                    cnt_d = cnt_q + CNT_W'(1);
                end
            end else if (hit) begin
                cnt_d = cnt_q + CNT_W'(1);
            end
        end
        if (bus_q == PESD_IDLE && avs_write_in && avs_address_in == `PESD_CNT_OFS) begin
            cnt_d = CNT_W'(lane_merge(32'(cnt_q), avs_writedata_in, avs_byteenable_in));
        end
    end

    // ------------------------------------------------------------------------
    // Avalon-MM slave: one wait cycle, then acknowledge
    // ------------------------------------------------------------------------
    always_comb begin
        bus_d = bus_q;
        sel_d = sel_q;
        rdata_d = rdata_q;
        wait_d = 1'b1;
        // Response only stands in the acknowledge cycle
        resp_d = 1'b0;
        unique case (bus_q)
            PESD_IDLE: begin
                if (avs_read_in || avs_write_in) begin
                    bus_d = PESD_ACK;
                    wait_d = 1'b0;
                    resp_d = 1'b0;
                    rdata_d = 32'h00000000;
                    unique case (avs_address_in)
                        `PESD_SEL_OFS: begin
                            rdata_d = 32'(sel_q);
                            if (avs_write_in) begin
                                sel_d = pesd_sel_t'(lane_merge(32'(sel_q), avs_writedata_in,
                                                               avs_byteenable_in));
                                sel_d.reserved = 5'h00;
                            end
                        end
                        `PESD_CNT_OFS: begin
                            rdata_d = 32'(cnt_q);
                        end
                        `PESD_STAT_OFS: begin
                            rdata_d = {28'h0000000, amount};
                        end
                        default: begin
                            resp_d = 1'b1;
                        end
                    endcase
                end
            end
            PESD_ACK: begin
                bus_d = PESD_IDLE;
            end
        endcase
    end

    // Register all state
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            sel_q <= pesd_sel_t'(`PESD_SEL_RESET);
            cnt_q <= CNT_W'(`PESD_CNT_RESET);
            above_q <= 1'b0;
            bus_q <= PESD_IDLE;
            rdata_q <= 32'h00000000;
            wait_q <= 1'b1;
            resp_q <= 1'b0;
        end else begin
            sel_q <= sel_d;
            cnt_q <= cnt_d;
            above_q <= above_d;
            bus_q <= bus_d;
            rdata_q <= rdata_d;
            wait_q <= wait_d;
            resp_q <= resp_d;
        end
    end

    assign avs_readdata_out = rdata_q;
    assign avs_waitrequest_out = wait_q;
    assign avs_response_out = resp_q;
    assign count_out = cnt_q;

endmodule
`default_nettype wire

/* File: bench/pesd_top_asserts.sv */
/*
 * Concurrent checks on the decoder's bus handshake and counter ports.
 * Assumes it is bound into pesd_top and sees only that module's ports.
 */
`timescale 1ns/1ps
`default_nettype none
module pesd_chk
    import pesd_pkg::*;
#(
    parameter int CNT_W = 32
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Watched ports
    input wire pesd_cond_t cond_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic avs_response_out,
    input wire logic [CNT_W-1:0] count_out
);
    // ------------------------------------------------------------
    // Handshake and counter properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);
    logic req;
    logic wr_near;
    // A request is pending on the bus
    assign req = avs_read_in | avs_write_in;
    property p_take; req && avs_waitrequest_out |=> !avs_waitrequest_out; endproperty
    a_take: assert property (p_take) else $error("request not acknowledged");
    property p_pulse; !avs_waitrequest_out |=> avs_waitrequest_out; endproperty
    a_pulse: assert property (p_pulse) else $error("acknowledge longer than one cycle");
    property p_cause; !avs_waitrequest_out |-> $past(req) && $past(avs_waitrequest_out); endproperty
    a_cause: assert property (p_cause) else $error("acknowledge without request");
    property p_resp; avs_response_out |-> !avs_waitrequest_out; endproperty
    a_resp: assert property (p_resp) else $error("error response outside acknowledge");
    property p_unmap;
        !avs_waitrequest_out && avs_read_in && avs_address_in == 4'hC
            |-> avs_response_out && avs_readdata_out == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
    property p_reset;
        disable iff (1'b0) reset_in |=> avs_waitrequest_out && count_out == '0;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");
    property p_step;
        !$past(avs_write_in) && !$past(avs_write_in, 2) && !$past(avs_write_in, 3)
            |-> (count_out - $past(count_out)) < 8;
    endproperty
    a_step: assert property (p_step) else $error("counter jumped");
    property p_idle;
        $past(cond_in) == '0 && $past(cond_in, 2) == '0 && !$past(avs_write_in)
            && !$past(avs_write_in, 2) && !$past(avs_write_in, 3) |-> $stable(count_out);
    endproperty
    a_idle: assert property (p_idle) else $error("counter moved with no condition");
endmodule

bind pesd_top pesd_chk #(.CNT_W(CNT_W)) u_pesd_chk (
    .clk_in(clk_in), .reset_in(reset_in), .cond_in(cond_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .avs_response_out(avs_response_out),
    .count_out(count_out)
);
`default_nettype wire

/* File: bench/tb.sv */
/*
 * Self-checking bench for the event select decoder: a table of selections
 * and conditions, then bus, reset and refusal cases.
 * Assumes the design package, header and top module are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pesd_pkg::*;
    typedef struct packed {
        logic [31:0] sel;
        pesd_cond_t c;
        logic [31:0] tot;
    } pesd_row_t;
    logic clk_in;
    logic reset_in;
    pesd_cond_t cond_in;
    pesd_cond_t c;
    logic [3:0] adr;
    logic rd;
    logic wr;
    logic [31:0] wdata;
    logic [3:0] lanes;
    logic [31:0] rdata;
    logic waitreq;
    logic resp;
    logic [31:0] count;
    logic [31:0] bus_rdata;
    logic [31:0] bus_resp;
    int n_mismatch;
    int checks;
    pesd_row_t rows[$];
    logic [7:0] pm[6];

    pesd_top u_pesd_top (
        .clk_in(clk_in), .reset_in(reset_in), .cond_in(cond_in),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wdata), .avs_byteenable_in(lanes),
        .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
        .avs_response_out(resp), .count_out(count)
    );

    // Clock of 100 ns period
    always #50 clk_in = ~clk_in;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("mismatches %0d, checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // One bus access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int n;
        @(posedge clk_in);
        wr <= w;
        rd <= !w;
        adr <= a;
        wdata <= d;
        lanes <= be;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (waitreq !== 1'b0 && n < 20);
        bus_rdata = rdata;
        bus_resp = {31'h0, resp};
        wr <= 1'b0;
        rd <= 1'b0;
        if (waitreq !== 1'b0) begin
            n_mismatch++;
            $display("CHECK FAILED %0t bus timeout", $time);
            report_and_stop();
        end
    endtask

    // Adds a row: select upper half, event, mask, expected total over 4 cycles
    task automatic r(input logic [15:0] hi, input logic [7:0] ev, input logic [7:0] um,
                     input logic [7:0] tot);
        rows.push_back('{{hi, um, ev}, c, {24'h0, tot}});
    endtask

    // Clears the counter, selects, holds the condition 4 cycles, checks the sum
    task automatic run(input pesd_row_t x);
        bus(1'b1, 4'h4, 32'h0, 4'hF);
        bus(1'b1, 4'h0, x.sel | 32'h0004_0000, 4'hF);
        @(posedge clk_in);
        cond_in <= x.c;
        repeat (4) @(posedge clk_in);
        cond_in <= '0;
        repeat (4) @(posedge clk_in);
        cmp(count, x.tot, "count");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        reset_in = 1'b1;
        cond_in = '0;
        adr = 4'h0;
        rd = 1'b0;
        wr = 1'b0;
        wdata = 32'h0;
        lanes = 4'h0;
        n_mismatch = 0;
        checks = 0;
        pm = '{8'h01, 8'h02, 8'h0C, 8'h30, 8'h40, 8'h80};
        repeat (6) @(posedge clk_in);
        reset_in <= 1'b0;
        bus(1'b0, 4'h0, 32'h0, 4'hF);
        cmp(bus_rdata, 32'h0, "select reset");
        bus(1'b0, 4'h4, 32'h0, 4'hF);
        cmp(bus_rdata, 32'h0, "counter reset");
        // Table of selections
        c = '0;
        c.uq_any_path = 3'h3;
        r(16'h0, 8'h79, 8'h3C, 8'h0C);
        r(16'h0, 8'h79, 8'h01, 8'h00);
        c = '0;
        c.fetch_stall = 1'b1;
        r(16'h0, 8'h80, 8'h04, 8'h04);
        r(16'h0, 8'h80, 8'h02, 8'h00);
        c.icache_miss = 1'b1;
        r(16'h0, 8'h80, 8'h02, 8'h04);
        c = '0;
        c.instr_translation_buffer_walk_done = 1'b1;
        r(16'h0, 8'h85, 8'h02, 8'h04);
        r(16'h0, 8'h85, 8'h01, 8'h00);
        r(16'h0, 8'h85, 8'h03, 8'h04);
        c = '0;
        c.second_level_translation_buffer_hit = 1'b1;
        r(16'h0, 8'h85, 8'h10, 8'h04);
        c = '0;
        c.iq_full = 1'b1;
        r(16'h0, 8'h87, 8'h04, 8'h04);
        r(16'h0, 8'h87, 8'h01, 8'h00);
        c = '0;
        c.br_valid = 1'b1;
        c.br_type = 6'h01;
        r(16'h0, 8'h88, 8'h41, 8'h04);
        r(16'h0, 8'h88, 8'hFF, 8'h04);
        r(16'h0, 8'h88, 8'h81, 8'h00);
        c.br_type = 6'h02;
        r(16'h0, 8'h88, 8'h42, 8'h00);
        r(16'h0, 8'h88, 8'h02, 8'h00);
        c.br_taken = 1'b1;
        r(16'h0, 8'h88, 8'h82, 8'h04);
        r(16'h0, 8'h88, 8'h80, 8'h00);
        r(16'h0, 8'h89, 8'h82, 8'h00);
        c.br_misp = 1'b1;
        r(16'h0, 8'h89, 8'h82, 8'h04);
        r(16'h0, 8'h89, 8'hFF, 8'h04);
        c = '0;
        c.undelivered = 3'h3;
        r(16'h0, 8'h9C, 8'h01, 8'h0C);
        r(16'h0100, 8'h9C, 8'h01, 8'h04);
        r(16'h0101, 8'h9C, 8'h01, 8'h01);
        for (int i = 0; i < 6; i++) begin
            c = '0;
            c.port_disp[i] = 1'b1;
            r(16'h0, 8'hA1, pm[i], 8'h04);
        end
        c = '0;
        c.stall_sb = 1'b1;
        r(16'h0, 8'hA2, 8'h08, 8'h04);
        r(16'h0, 8'hA2, 8'h0C, 8'h04);
        r(16'h0, 8'hA2, 8'h10, 8'h00);
        c = '0;
        c.pend_other = 4'hF;
        r(16'h0, 8'hA3, 8'h01, 8'h00);
        r(16'h0002, 8'hA3, 8'h01, 8'h04);
        c.pend_thread = 4'hF;
        r(16'h0, 8'hA3, 8'h02, 8'h04);
        r(16'h0, 8'hA3, 8'h08, 8'h00);
        c = '0;
        c.lsd_uops = 3'h2;
        r(16'h0, 8'hA8, 8'h01, 8'h08);
        c = '0;
        c.switch_penalty = 1'b1;
        r(16'h0, 8'hAB, 8'h02, 8'h04);
        r(16'h0, 8'hAB, 8'h01, 8'h00);
        c = '0;
        c.opc_fill_big = 1'b1;
        r(16'h0, 8'hAC, 8'h08, 8'h04);
        c = '0;
        c.instr_translation_buffer_flush = 1'b1;
        r(16'h0, 8'hAE, 8'h01, 8'h04);
        c = '0;
        c.req_rfo = 1'b1;
        r(16'h0, 8'hB0, 8'h04, 8'h04);
        r(16'h0, 8'hB0, 8'h01, 8'h00);
        c = '1;
        r(16'h0, 8'h50, 8'hFF, 8'h00);
        foreach (rows[i]) run(rows[i]);
        // Byte lanes, unlisted event select, unmapped and read-only places
        bus(1'b1, 4'h0, 32'hFFFF_FFFF, 4'h3);
        bus(1'b1, 4'h4, 32'h1234_5678, 4'hF);
        cond_in <= '1;
        bus(1'b0, 4'h4, 32'h0, 4'hF);
        cmp(bus_rdata, 32'h1234_5678, "unlisted select");
        cond_in <= '0;
        bus(1'b1, 4'hC, 32'hFFFF_FFFF, 4'hF);
        bus(1'b0, 4'hC, 32'h0, 4'hF);
        cmp(bus_rdata, 32'h0, "unmapped data");
        cmp(bus_resp, 32'h1, "unmapped response");
        bus(1'b0, 4'h0, 32'h0, 4'hF);
        cmp(bus_rdata, 32'h0004_FFFF, "lane merge");
        bus(1'b1, 4'h0, 32'h0004_3C79, 4'hF);
        c = '0;
        c.uq_any_path = 3'h3;
        cond_in <= c;
        bus(1'b1, 4'h8, 32'hFFFF_FFFF, 4'hF);
        bus(1'b0, 4'h8, 32'h0, 4'hF);
        cmp(bus_rdata, 32'h3, "status amount");
        cmp(bus_resp, 32'h0, "status response");
        // Reset in mid-count
        reset_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        cond_in <= '0;
        repeat (2) @(posedge clk_in);
        cmp(count, 32'h0, "count after reset");
        bus(1'b0, 4'h0, 32'h0, 4'hF);
        cmp(bus_rdata, 32'h0, "select after reset");
        report_and_stop();
    end
endmodule
`default_nettype wire
